// ==== rtl/btds_pkg.sv ====
package btds_pkg;
	localparam int ADDR_W = 64;
	localparam int WORD_W = 32;
	localparam int CNT_W = 4;
	localparam int PMC_W = 40;
	localparam int GPR_COUNT = 8;
	localparam int MISPRED_BIT = 63;
	localparam int PRED_BIT = 4;
	localparam int BR_PRED_WORD = 2;
	localparam int REC_WORDS = 10;

	// record-format codes of the capability field
	localparam logic [5:0] FMT_SEG_OFS = 6'h00;
	localparam logic [5:0] FMT_LIN_64 = 6'h01;
	localparam logic [5:0] FMT_EIP_64 = 6'h02;
	localparam logic [5:0] FMT_EIP_FLAGS = 6'h03;
	localparam logic [5:0] LBR_FMT = FMT_EIP_FLAGS;

	// identification outputs
	localparam logic PERF_CAP_PRESENT = 1'b1;
	localparam logic DEBUG_STORE_PRESENT = 1'b1;
	localparam logic BRANCH_STORE_ABSENT = 1'b0;
	localparam logic SAMPLING_ABSENT = 1'b0;

	// buffer management area, 32-bit field layout
	localparam logic [63:0] MGMT_BR_OFS = 64'h0;
	localparam logic [63:0] MGMT_SMP_OFS = 64'h10;
	localparam logic [63:0] FLD_INDEX_OFS = 64'h4;
	localparam logic [CNT_W-1:0] FLD_BASE = 4'h0;
	localparam logic [CNT_W-1:0] FLD_INDEX = 4'h1;
	localparam logic [CNT_W-1:0] FLD_MAX = 4'h2;
	localparam logic [CNT_W-1:0] FLD_THR = 4'h3;
	localparam logic [CNT_W-1:0] FLD_RST_LO = 4'h4;
	localparam logic [CNT_W-1:0] FLD_RST_HI = 4'h5;
	localparam logic [CNT_W-1:0] BR_FETCH_LAST = 4'h3;
	localparam logic [CNT_W-1:0] SMP_FETCH_LAST = 4'h5;
	localparam logic [CNT_W-1:0] BR_WORD_LAST = 4'h2;
	localparam logic [CNT_W-1:0] SMP_WORD_LAST = 4'h9;
	localparam logic [31:0] BR_BYTES = 32'h0000000c;
	localparam logic [31:0] SMP_BYTES = 32'h00000028;
	localparam logic [PMC_W-1:0] PMC_MAX = 40'hffffffffff;

	typedef enum logic [1:0] {
		S_IDLE = 2'b00,
		S_FETCH = 2'b01,
		S_WRITE = 2'b10,
		S_INDEX = 2'b11
	} btds_state_t;
endpackage

// ==== rtl/btds_addr_fmt.sv ====
`timescale 1ns/10ps
`default_nettype none
module btds_addr_fmt
	import btds_pkg::*;
(
	input wire logic [ADDR_W-1:0] i_addr,
	input wire logic i_long_mode,
	input wire logic i_full_64,
	output logic [ADDR_W-1:0] o_addr
);
	always_comb begin
		// low half only outside long mode, upper half cleared in compatibility mode
		if (i_long_mode && i_full_64) begin
			o_addr = i_addr;
		end else begin
			o_addr = {32'h0, i_addr[31:0]};
		end
	end
endmodule
`default_nettype wire

// ==== rtl/btds_top.sv ====
`timescale 1ns/10ps
`default_nettype none
module btds_top
	import btds_pkg::*;
(
	input wire logic i_clk,
	input wire logic i_arst_n,
	input wire logic i_ce,
	input wire logic i_ctl_write,
	input wire logic i_ctl_trace,
	input wire logic i_ctl_store,
	input wire logic i_ctl_irq,
	input wire logic i_ctl_sample,
	input wire logic i_smm,
	input wire logic i_machine_check,
	input wire logic i_init,
	input wire logic i_long_mode,
	input wire logic i_full_64,
	input wire logic i_br_valid,
	input wire logic [ADDR_W-1:0] i_br_from,
	input wire logic [ADDR_W-1:0] i_br_to,
	input wire logic i_br_predicted,
	input wire logic i_br_is_exc,
	input wire logic i_pmc_event,
	input wire logic i_pmc_write,
	input wire logic [PMC_W-1:0] i_pmc_wdata,
	input wire logic [GPR_COUNT*WORD_W-1:0] i_gpr,
	input wire logic [WORD_W-1:0] i_ip,
	input wire logic [WORD_W-1:0] i_cs_base,
	input wire logic [WORD_W-1:0] i_flags_register,
	input wire logic [ADDR_W-1:0] i_store_area_base_reg,
	input wire logic i_mem_ack,
	input wire logic [WORD_W-1:0] i_mem_rdata,
	output logic o_mem_req,
	output logic o_mem_we,
	output logic [ADDR_W-1:0] o_mem_addr,
	output logic [WORD_W-1:0] o_mem_wdata,
	output logic o_busy,
	output logic o_buffer_irq,
	output logic o_branch_trace_message,
	output logic [ADDR_W-1:0] o_last_branch_record_from,
	output logic [ADDR_W-1:0] o_last_branch_record_to,
	output logic [ADDR_W-1:0] o_last_branch_legacy,
	output logic [ADDR_W-1:0] o_last_exception_record_from,
	output logic [ADDR_W-1:0] o_last_exception_record_to,
	output logic [5:0] o_perf_capability_reg,
	output logic o_perf_capability_present,
	output logic o_debug_store_present,
	output logic o_branch_store_absent_flag,
	output logic o_sampling_absent_flag,
	output logic o_trace_message_enable,
	output logic o_branch_store_enable,
	output logic o_branch_buffer_irq_enable,
	output logic o_sampling_enable,
	output logic [PMC_W-1:0] o_pmc
);
	logic [1:0] rst_q;
	logic rst_n;
	logic [ADDR_W-1:0] raw_addr [2];
	logic [ADDR_W-1:0] fmt_addr [2];
	logic [ADDR_W-1:0] from_val;

	btds_state_t st, next_st;
	logic [CNT_W-1:0] cnt, next_cnt;
	logic is_smp, next_is_smp;
	logic ctl_trace, next_ctl_trace;
	logic ctl_store, next_ctl_store;
	logic ctl_irq, next_ctl_irq;
	logic smp_en, next_smp_en;
	logic armed, next_armed;
	logic [PMC_W-1:0] pmc, next_pmc;
	logic [31:0] f_base, next_f_base;
	logic [31:0] f_idx, next_f_idx;
	logic [31:0] f_max, next_f_max;
	logic [31:0] f_thr, next_f_thr;
	logic [31:0] f_rlo, next_f_rlo;
	logic [31:0] f_rhi, next_f_rhi;
	logic [WORD_W-1:0] rec [REC_WORDS];
	logic [WORD_W-1:0] next_rec [REC_WORDS];
	logic irq, next_irq;
	logic msg, next_msg;
	logic [ADDR_W-1:0] lbr_from, next_lbr_from;
	logic [ADDR_W-1:0] lbr_to, next_lbr_to;
	logic [ADDR_W-1:0] lbr_leg, next_lbr_leg;
	logic [ADDR_W-1:0] ler_from, next_ler_from;
	logic [ADDR_W-1:0] ler_to, next_ler_to;

	logic br_go;
	logic smp_go;
	logic [31:0] rec_bytes;
	logic [31:0] idx_adv;
	logic no_room;
	logic wrap;
	logic [31:0] new_idx;
	logic thr_hit;
	logic [ADDR_W-1:0] mgmt_base;

	always_ff @(posedge i_clk or negedge i_arst_n) begin
		if (!i_arst_n) begin
			rst_q <= 2'b00;
		end else begin
			rst_q <= {rst_q[0], 1'b1};
		end
	end
	assign rst_n = rst_q[1];

	assign raw_addr[0] = i_br_from;
	assign raw_addr[1] = i_br_to;
	for (genvar g = 0; g < 2; g++) begin : g_fmt
		btds_addr_fmt u_fmt (
			.i_addr(raw_addr[g]),
			.i_long_mode(i_long_mode),
			.i_full_64(i_full_64),
			.o_addr(fmt_addr[g])
		);
	end

	always_comb begin
		from_val = fmt_addr[0];
		if (LBR_FMT == FMT_EIP_FLAGS) begin
			from_val[MISPRED_BIT] = ~i_br_predicted;
		end
	end

	// recording only outside management mode, in any other cpu mode
	assign br_go = i_br_valid && ctl_trace && ctl_store && !i_smm;
	assign smp_go = armed && smp_en && i_pmc_event && !i_smm;
	assign rec_bytes = is_smp ? SMP_BYTES : BR_BYTES;
	assign idx_adv = 32'(f_idx + rec_bytes);
	assign no_room = 33'(f_idx) + 33'(rec_bytes) > 33'(f_max);
	assign wrap = !is_smp && !ctl_irq && (33'(idx_adv) + 33'(BR_BYTES) > 33'(f_max));
	assign new_idx = wrap ? f_base : idx_adv;
	assign thr_hit = (f_idx == f_thr);
	assign mgmt_base = 64'(i_store_area_base_reg + (is_smp ? MGMT_SMP_OFS : MGMT_BR_OFS));

	always_comb begin
		next_st = st;
		next_cnt = cnt;
		next_is_smp = is_smp;
		next_ctl_trace = ctl_trace;
		next_ctl_store = ctl_store;
		next_ctl_irq = ctl_irq;
		next_smp_en = smp_en;
		next_armed = armed;
		next_pmc = pmc;
		next_f_base = f_base;
		next_f_idx = f_idx;
		next_f_max = f_max;
		next_f_thr = f_thr;
		next_f_rlo = f_rlo;
		next_f_rhi = f_rhi;
		next_rec = rec;
		next_irq = 1'b0;
		next_msg = 1'b0;
		next_lbr_from = lbr_from;
		next_lbr_to = lbr_to;
		next_lbr_leg = lbr_leg;
		next_ler_from = ler_from;
		next_ler_to = ler_to;
		if (i_ctl_write) begin
			next_ctl_trace = i_ctl_trace;
			next_ctl_store = i_ctl_store;
			next_ctl_irq = i_ctl_irq;
			next_smp_en = i_ctl_sample;
		end
		if (i_smm || i_machine_check || i_init) begin
			next_ctl_trace = 1'b0;
			next_ctl_store = 1'b0;
			next_ctl_irq = 1'b0;
			next_smp_en = 1'b0;
		end
		if (i_br_valid) begin
			next_lbr_from = from_val;
			next_lbr_to = fmt_addr[1];
			next_lbr_leg = {i_br_to[31:0], i_br_from[31:0]};
			if (i_br_is_exc) begin
				next_ler_from = from_val;
				next_ler_to = fmt_addr[1];
			end
			if (ctl_trace && !ctl_store) begin
				next_msg = 1'b1;
			end
		end
		if (smp_en && i_pmc_event) begin
			next_pmc = 40'(pmc + 40'h1);
			if (pmc == PMC_MAX) begin
				next_armed = 1'b1;
			end
		end
		// software preset of the counter, so an overflow is reachable
		if (i_pmc_write) begin
			next_pmc = i_pmc_wdata;
		end
		unique case (st)
			S_IDLE: begin
				next_cnt = '0;
				if (smp_go) begin
					next_is_smp = 1'b1;
					next_st = S_FETCH;
					next_rec[0] = i_flags_register;
					next_rec[1] = 32'(i_ip + i_cs_base);
					for (int k = 0; k < GPR_COUNT; k++) begin
						next_rec[k + 2] = i_gpr[k*WORD_W +: WORD_W];
					end
				end else if (br_go) begin
					next_is_smp = 1'b0;
					next_st = S_FETCH;
					next_rec[0] = i_br_from[31:0];
					next_rec[1] = i_br_to[31:0];
					next_rec[BR_PRED_WORD] = '0;
					next_rec[BR_PRED_WORD][PRED_BIT] = i_br_predicted;
				end
			end
			S_FETCH: begin
				if (i_mem_ack) begin
					case (cnt)
						FLD_BASE: next_f_base = i_mem_rdata;
						FLD_INDEX: next_f_idx = i_mem_rdata;
						FLD_MAX: next_f_max = i_mem_rdata;
						FLD_THR: next_f_thr = i_mem_rdata;
						FLD_RST_LO: next_f_rlo = i_mem_rdata;
						FLD_RST_HI: next_f_rhi = i_mem_rdata;
						default: next_f_base = f_base;
					endcase
					next_cnt = 4'(cnt + 4'h1);
					if (cnt == (is_smp ? SMP_FETCH_LAST : BR_FETCH_LAST)) begin
						next_cnt = '0;
						next_st = no_room ? S_IDLE : S_WRITE;
					end
				end
			end
			S_WRITE: begin
				if (i_mem_ack) begin
					next_cnt = 4'(cnt + 4'h1);
					if (cnt == (is_smp ? SMP_WORD_LAST : BR_WORD_LAST)) begin
						next_cnt = '0;
						next_st = S_INDEX;
					end
				end
			end
			S_INDEX: begin
				if (i_mem_ack) begin
					next_st = S_IDLE;
					next_irq = thr_hit;
					if (is_smp) begin
						next_pmc = {f_rhi[7:0], f_rlo};
						next_armed = 1'b0;
					end
				end
			end
		endcase
	end

	always_ff @(posedge i_clk or negedge rst_n) begin
		if (!rst_n) begin
			st <= S_IDLE;
			cnt <= '0;
			is_smp <= 1'b0;
			ctl_trace <= 1'b0;
			ctl_store <= 1'b0;
			ctl_irq <= 1'b0;
			smp_en <= 1'b0;
			armed <= 1'b0;
			pmc <= '0;
			f_base <= '0;
			f_idx <= '0;
			f_max <= '0;
			f_thr <= '0;
			f_rlo <= '0;
			f_rhi <= '0;
			rec <= '{default: '0};
			irq <= 1'b0;
			msg <= 1'b0;
			lbr_from <= '0;
			lbr_to <= '0;
			lbr_leg <= '0;
			ler_from <= '0;
			ler_to <= '0;
		end else if (i_ce) begin
			st <= next_st;
			cnt <= next_cnt;
			is_smp <= next_is_smp;
			ctl_trace <= next_ctl_trace;
			ctl_store <= next_ctl_store;
			ctl_irq <= next_ctl_irq;
			smp_en <= next_smp_en;
			armed <= next_armed;
			pmc <= next_pmc;
			f_base <= next_f_base;
			f_idx <= next_f_idx;
			f_max <= next_f_max;
			f_thr <= next_f_thr;
			f_rlo <= next_f_rlo;
			f_rhi <= next_f_rhi;
			rec <= next_rec;
			irq <= next_irq;
			msg <= next_msg;
			lbr_from <= next_lbr_from;
			lbr_to <= next_lbr_to;
			lbr_leg <= next_lbr_leg;
			ler_from <= next_ler_from;
			ler_to <= next_ler_to;
		end
	end

	// memory port: request held until acknowledged
	always_comb begin
		o_mem_addr = '0;
		o_mem_wdata = '0;
		unique case (st)
			S_IDLE: o_mem_addr = '0;
			S_FETCH: o_mem_addr = 64'(mgmt_base + {cnt, 2'b00});
			S_WRITE: begin
				o_mem_addr = 64'({32'h0, f_idx} + {cnt, 2'b00});
				o_mem_wdata = rec[cnt];
			end
			S_INDEX: begin
				o_mem_addr = 64'(mgmt_base + FLD_INDEX_OFS);
				o_mem_wdata = new_idx;
			end
		endcase
	end
	assign o_mem_req = (st != S_IDLE);
	assign o_mem_we = (st == S_WRITE) || (st == S_INDEX);
	assign o_busy = (st != S_IDLE);
	assign o_buffer_irq = irq;
	assign o_branch_trace_message = msg;
	assign o_last_branch_record_from = lbr_from;
	assign o_last_branch_record_to = lbr_to;
	assign o_last_branch_legacy = lbr_leg;
	assign o_last_exception_record_from = ler_from;
	assign o_last_exception_record_to = ler_to;
	assign o_perf_capability_reg = LBR_FMT;
	assign o_perf_capability_present = PERF_CAP_PRESENT;
	assign o_debug_store_present = DEBUG_STORE_PRESENT;
	assign o_branch_store_absent_flag = BRANCH_STORE_ABSENT;
	assign o_sampling_absent_flag = SAMPLING_ABSENT;
	assign o_trace_message_enable = ctl_trace;
	assign o_branch_store_enable = ctl_store;
	assign o_branch_buffer_irq_enable = ctl_irq;
	assign o_sampling_enable = smp_en;
	assign o_pmc = pmc;

	default clocking cb @(posedge i_clk); endclocking
	default disable iff (!rst_n || !i_ce);

	sequence s_br_req;
		st == S_IDLE && br_go && !smp_go;
	endsequence
	sequence s_rec_done;
		st == S_INDEX && i_mem_ack;
	endsequence

	chk_lbr_low_only: assert property (
		i_br_valid && !i_long_mode |=> o_last_branch_record_to[63:32] == 32'h0)
		else $error("branch record upper half not zero outside long mode");
	chk_full_64_keep: assert property (
		i_br_valid && i_long_mode && i_full_64 |=> o_last_branch_record_to == $past(i_br_to))
		else $error("full 64-bit destination not stored");
	chk_ler_follow: assert property (
		i_br_valid && i_br_is_exc |=> o_last_exception_record_to == o_last_branch_record_to)
		else $error("exception record differs from branch record");
	chk_flag_bit: assert property (
		i_br_valid |=> o_last_branch_record_from[MISPRED_BIT] == !$past(i_br_predicted))
		else $error("mispredict flag wrong in source record");
	chk_stop_clear: assert property (
		i_smm || i_machine_check || i_init |=> !o_branch_store_enable && !o_sampling_enable)
		else $error("recording enable survived stop condition");
	chk_branch_start: assert property (
		s_br_req |=> st == S_FETCH && !is_smp ##1 o_mem_req)
		else $error("branch record not started");
	chk_pred_word: assert property (
		s_br_req ##0 i_br_predicted |=> rec[BR_PRED_WORD][PRED_BIT])
		else $error("predicted bit not in third record word");
	chk_index_adv: assert property (
		st == S_INDEX && !is_smp |-> o_mem_wdata == 32'(f_idx + BR_BYTES) || o_mem_wdata == f_base)
		else $error("branch index not advanced by one record");
	chk_thr_irq: assert property (
		s_rec_done ##0 thr_hit |=> o_buffer_irq ##1 !o_buffer_irq)
		else $error("threshold interrupt missing or stretched");
	chk_reload: assert property (
		s_rec_done ##0 is_smp |=> o_pmc == {f_rhi[7:0], f_rlo} && !armed)
		else $error("counter not reloaded after sample");
	chk_sample_ip: assert property (
		st == S_IDLE && smp_go |=> rec[1] == 32'($past(i_ip) + $past(i_cs_base)))
		else $error("sample pointer not linear");
	chk_msg_excl: assert property (
		i_br_valid && ctl_trace && ctl_store |=> !o_branch_trace_message)
		else $error("bus message sent while storing");
	chk_cap_format: assert property (
		o_perf_capability_reg == FMT_EIP_FLAGS)
		else $error("record format code wrong");
endmodule
`default_nettype wire

// ==== bench/btds_mem_model.sv ====
`timescale 1ns/10ps
`default_nettype none
module btds_mem_model
	import btds_pkg::*;
(
	input wire logic i_clk,
	input wire logic i_arst_n,
	input wire logic i_req,
	input wire logic i_we,
	input wire logic [ADDR_W-1:0] i_addr,
	input wire logic [WORD_W-1:0] i_wdata,
	input wire logic i_slow,
	output logic o_ack,
	output logic [WORD_W-1:0] o_rdata
);
	logic [WORD_W-1:0] mem [0:255];
	logic [1:0] wait_cnt;

	// read data toggles whenever no ack is given
	always @(posedge i_clk or negedge i_arst_n) begin
		if (!i_arst_n) begin
			o_ack <= 1'b0;
			o_rdata <= 32'h0;
			wait_cnt <= 2'h0;
		end else if (o_ack || !i_req) begin
			o_ack <= 1'b0;
			o_rdata <= ~o_rdata;
			wait_cnt <= 2'h0;
			if (o_ack && i_req && i_we) begin
				mem[i_addr[9:2]] <= i_wdata;
			end
		end else if (i_slow && wait_cnt != 2'h3) begin
			wait_cnt <= wait_cnt + 2'h1;
			o_rdata <= ~o_rdata;
		end else begin
			o_ack <= 1'b1;
			o_rdata <= i_we ? ~o_rdata : mem[i_addr[9:2]];
		end
	end
endmodule
`default_nettype wire

// ==== bench/btds_top_tb_top.sv ====
`timescale 1ns/10ps
`default_nettype none
module btds_top_tb_top;
	import btds_pkg::*;
	logic i_clk, i_arst_n, i_ce, i_ctl_write, i_ctl_trace, i_ctl_store, i_ctl_irq;
	logic i_ctl_sample, i_smm, i_machine_check, i_init, i_long_mode, i_full_64;
	logic i_br_valid, i_br_predicted, i_br_is_exc, i_pmc_event, i_mem_ack, slow, i_pmc_write;
	logic [ADDR_W-1:0] i_br_from, i_br_to, i_store_area_base_reg, o_mem_addr;
	logic [GPR_COUNT*WORD_W-1:0] i_gpr;
	logic [WORD_W-1:0] i_ip, i_cs_base, i_flags_register, i_mem_rdata, o_mem_wdata;
	logic o_mem_req, o_mem_we, o_busy, o_buffer_irq, o_branch_trace_message;
	logic [ADDR_W-1:0] lbr_from, lbr_to, lbr_leg, ler_from, ler_to;
	logic [5:0] fmt;
	logic cap_p, ds_p, bs_abs, smp_abs, en_tr, en_st, en_irq, en_smp;
	logic [PMC_W-1:0] o_pmc, i_pmc_wdata;
	int failures = 0;
	int tests_run = 0;
	int irq_cnt = 0;

	btds_top dut (.i_clk, .i_arst_n, .i_ce, .i_ctl_write, .i_ctl_trace, .i_ctl_store,
		.i_ctl_irq, .i_ctl_sample, .i_smm, .i_machine_check, .i_init, .i_long_mode,
		.i_full_64, .i_br_valid, .i_br_from, .i_br_to, .i_br_predicted, .i_br_is_exc,
		.i_pmc_event, .i_pmc_write, .i_pmc_wdata, .i_gpr, .i_ip, .i_cs_base,
		.i_flags_register,
		.i_store_area_base_reg, .i_mem_ack, .i_mem_rdata, .o_mem_req, .o_mem_we,
		.o_mem_addr, .o_mem_wdata, .o_busy, .o_buffer_irq, .o_branch_trace_message,
		.o_last_branch_record_from(lbr_from), .o_last_branch_record_to(lbr_to),
		.o_last_branch_legacy(lbr_leg), .o_last_exception_record_from(ler_from),
		.o_last_exception_record_to(ler_to), .o_perf_capability_reg(fmt),
		.o_perf_capability_present(cap_p), .o_debug_store_present(ds_p),
		.o_branch_store_absent_flag(bs_abs), .o_sampling_absent_flag(smp_abs),
		.o_trace_message_enable(en_tr), .o_branch_store_enable(en_st),
		.o_branch_buffer_irq_enable(en_irq), .o_sampling_enable(en_smp), .o_pmc);

	btds_mem_model mem (.i_clk, .i_arst_n, .i_req(o_mem_req), .i_we(o_mem_we),
		.i_addr(o_mem_addr), .i_wdata(o_mem_wdata), .i_slow(slow), .o_ack(i_mem_ack),
		.o_rdata(i_mem_rdata));

	initial begin
		i_clk = 1'b0;
		forever #4 i_clk = ~i_clk;
	end

	always @(posedge i_clk) begin
		if (o_buffer_irq === 1'b1) irq_cnt++;
	end

	task automatic end_sim;
		if (failures == 0 && tests_run > 0) $display("DONE - PASS");
		else $display("DONE - FAIL");
		$finish;
	endtask

	task automatic chk(input logic [63:0] seen, input logic [63:0] exp);
		tests_run++;
		if (seen !== exp) begin
			failures++;
			$display("[ERR] %0t seen %h exp %h", $time, seen, exp);
		end
	endtask

	task automatic tick;
		@(posedge i_clk);
		#1;
	endtask

	task automatic ctl(input logic [3:0] v);
		{i_ctl_trace, i_ctl_store, i_ctl_irq, i_ctl_sample} = v;
		i_ctl_write = 1'b1;
		tick;
		i_ctl_write = 1'b0;
	endtask

	task automatic br(input logic [63:0] f, input logic [63:0] t, input logic p);
		i_br_from = f;
		i_br_to = t;
		i_br_predicted = p;
		i_br_valid = 1'b1;
		tick;
		i_br_valid = 1'b0;
	endtask

	task automatic wait_idle;
		int n;
		n = 0;
		tick;
		while (o_busy !== 1'b0 && n < 300) begin
			tick;
			n++;
		end
		if (o_busy !== 1'b0) begin
			failures++;
			end_sim;
		end else begin
			tick;
		end
	endtask

	// management area at 0x100, buffer base 0x200, four records
	task automatic area(input logic [31:0] idx, input logic [31:0] thr);
		mem.mem[8'h40] = 32'h200;
		mem.mem[8'h41] = idx;
		mem.mem[8'h42] = 32'h231;
		mem.mem[8'h43] = thr;
	endtask

	task automatic t_const;
		chk(fmt, 6'h03);
		chk(cap_p, 1'b1);
		chk(ds_p, 1'b1);
		chk(bs_abs, 1'b0);
		chk(smp_abs, 1'b0);
	endtask

	task automatic t_pmc;
		ctl(4'b0001);
		i_pmc_event = 1'b1;
		repeat (5) tick;
		chk(o_pmc, 40'h5);
		i_ce = 1'b0;
		repeat (3) tick;
		chk(o_pmc, 40'h5);
		i_ce = 1'b1;
		i_pmc_event = 1'b0;
	endtask

	// sample area at 0x110, buffer 0x300, two records
	task automatic t_sample;
		int n0;
		ctl(4'b0001);
		mem.mem[8'h44] = 32'h300;
		mem.mem[8'h45] = 32'h300;
		mem.mem[8'h46] = 32'h351;
		mem.mem[8'h47] = 32'h300;
		mem.mem[8'h48] = 32'h89abcdef;
		mem.mem[8'h49] = 32'hffffff12;
		for (int k = 0; k < GPR_COUNT; k++) begin
			i_gpr[k*WORD_W +: WORD_W] = 32'hc0de_0000 + 32'(k);
		end
		n0 = irq_cnt;
		i_pmc_wdata = 40'hfffffffffe;
		i_pmc_write = 1'b1;
		tick;
		i_pmc_write = 1'b0;
		i_pmc_event = 1'b1;
		repeat (3) tick;
		i_pmc_event = 1'b0;
		chk(o_busy, 1'b1);
		wait_idle;
		chk(mem.mem[8'hc0], 32'h202);
		chk(mem.mem[8'hc1], 32'h3000);
		for (int k = 0; k < GPR_COUNT; k++) begin
			chk(mem.mem[8'hc2 + 8'(k)], 32'hc0de_0000 + 32'(k));
		end
		chk(mem.mem[8'h45], 32'h328);
		chk(o_pmc, 40'h12_89ab_cdef);
		chk(irq_cnt - n0, 1);
	endtask

	task automatic t_reset;
		ctl(4'b1111);
		i_arst_n = 1'b0;
		tick;
		chk({en_tr, en_st, en_irq, en_smp, o_busy}, 5'h00);
		chk(o_pmc, 40'h0);
		i_arst_n = 1'b1;
		repeat (3) tick;
		br(64'h55, 64'h66, 1'b1);
		chk(lbr_to, 64'h66);
	endtask

	task automatic t_format;
		logic [63:0] f, t, ef, et;
		ctl(4'b1000);
		i_br_is_exc = 1'b1;
		for (int m = 0; m < 4; m++) begin
			{i_long_mode, i_full_64} = m[1:0];
			f = 64'h8765_4321_0fed_cba8 ^ 64'(m);
			t = 64'h1357_9bdf_2468_ace0 + 64'(m);
			br(f, t, m[0]);
			ef = (m == 3) ? f : {32'h0, f[31:0]};
			et = (m == 3) ? t : {32'h0, t[31:0]};
			ef[63] = !m[0];
			chk(lbr_from, ef);
			chk(lbr_to, et);
			chk(lbr_leg, {t[31:0], f[31:0]});
			chk(ler_from, ef);
			chk(ler_to, et);
			chk({o_branch_trace_message, o_busy}, 2'b10);
			tick;
		end
		i_br_is_exc = 1'b0;
		br(64'h11, 64'h22, 1'b1);
		chk(ler_to, et);
	endtask

	task automatic t_store;
		int n0;
		logic [7:0] a;
		ctl(4'b1110);
		i_long_mode = 1'b0;
		area(32'h200, 32'h20c);
		for (int k = 0; k < 2; k++) begin
			slow = k[0];
			n0 = irq_cnt;
			a = 8'h80 + 8'(3 * k);
			br(64'h4000_0100 + 64'(k), 64'h5000_0200 + 64'(k), k[0]);
			wait_idle;
			chk(mem.mem[a], 32'h4000_0100 + 32'(k));
			chk(mem.mem[a + 8'h1], 32'h5000_0200 + 32'(k));
			chk(mem.mem[a + 8'h2], k ? 32'h10 : 32'h0);
			chk(mem.mem[8'h41], 32'h20c + 32'(12 * k));
			chk(irq_cnt - n0, k);
		end
		slow = 1'b0;
	endtask

	task automatic t_circ;
		ctl(4'b1100);
		area(32'h224, 32'h3f0);
		br(64'h77, 64'h88, 1'b0);
		wait_idle;
		chk(mem.mem[8'h89], 32'h77);
		chk(mem.mem[8'h41], 32'h200);
		ctl(4'b1110);
		area(32'h230, 32'h3f0);
		mem.mem[8'h8c] = 32'h5a5a5a5a;
		br(64'h99, 64'haa, 1'b0);
		wait_idle;
		chk({mem.mem[8'h8c], mem.mem[8'h41]}, {32'h5a5a5a5a, 32'h230});
	endtask

	task automatic t_clear;
		for (int s = 0; s < 3; s++) begin
			ctl(4'b1111);
			chk({en_tr, en_st, en_irq, en_smp}, 4'hf);
			{i_smm, i_machine_check, i_init} = 3'b100 >> s;
			tick;
			chk({en_tr, en_st, en_irq, en_smp}, 4'h0);
			if (s == 0) begin
				ctl(4'b1111);
				br(64'h33, 64'h44, 1'b0);
				chk({en_st, o_busy}, 2'b00);
			end
			{i_smm, i_machine_check, i_init} = 3'b000;
		end
	endtask

	initial begin
		{i_ce, i_ctl_write, i_ctl_trace, i_ctl_store, i_ctl_irq, i_ctl_sample} = 6'h20;
		{i_smm, i_machine_check, i_init, i_long_mode, i_full_64} = 5'h00;
		{i_br_valid, i_br_predicted, i_br_is_exc, i_pmc_event, slow, i_pmc_write} = 6'h00;
		i_pmc_wdata = 40'h0;
		i_br_from = 64'h0;
		i_br_to = 64'h0;
		i_store_area_base_reg = 64'h100;
		i_gpr = {8{32'h0badf00d}};
		i_ip = 32'h1000;
		i_cs_base = 32'h2000;
		i_flags_register = 32'h202;
		i_arst_n = 1'b0;
		repeat (3) @(posedge i_clk);
		#1;
		i_arst_n = 1'b1;
		repeat (3) tick;
		t_const;
		t_pmc;
		t_format;
		t_store;
		t_circ;
		t_sample;
		t_clear;
		t_reset;
		end_sim;
	end
endmodule
`default_nettype wire
